/* core/ucr_uart.sv */
// Purpose: Byte-register serial transceiver with modem control
// Assumes: One clock; all pins synchronous to core_clk
// Notes:   master_reset is the documented reset; reset_n powers up all
// Contract
// - Master reset zeroes enables, format, modem control; ident reads 01
// - Each interrupt source drops on its own read or write, or reset
// - Master reset sets line status low bits 110 0000; bit 7 reads 0
// - Master reset clears modem change flags; state bits follow pins
// - Length code 00..11 selects 5 to 8 data bits both ways
// - Stop-count bit 0 gives one stop bit sent and checked
// - Stop-count 1 with 5-bit length sends one and a half stops
// - Line control reads back what was last written
// - Offset 0 reads receive buffer, writes holding register
// - Offsets 1 to 7 decode; divisor select maps 0,1 to divisor
// - Modem status holds four change flags low, four states high
// - Line control bit 7 is the divisor select bit
// - Bits 3 to 6 are parity on, even, stick, set break
// - Line status bits 0-6 and modem control bits 0-4 as mapped
// - Enable bits 0-3; ident bit 0 low when pending, id in 2:1
// - Longer lengths with stop-count 1 send two stops, check one
// - Parity follows data; odd or even; stick forces inverse select
// - Set break forces serial output low outside loopback, transmitter untouched
// - Modem state bits are the complement of active-low pins; in loopback they are modem control bits
`timescale 1ns/1ps
`default_nettype none

module ucr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             clear,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrIdx;
    logic [AW-1:0]    rdIdx;
    logic [AW:0]      count;
    logic             doPush;
    logic             doPop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] i);
        bump = (32'(i) == DEPTH - 1) ? '0 : i + 1'b1;
    endfunction

    assign inReady  = (count != FULL);
    assign outValid = (count != '0);
    assign outData  = store[rdIdx];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    always_ff @(posedge core_clk) begin
        if (doPush) begin
            store[wrIdx] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clear) begin
            wrIdx <= '0;
            rdIdx <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrIdx <= bump(wrIdx);
            end
            if (doPop) begin
                rdIdx <= bump(rdIdx);
            end
            count <= count + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
        end
    end
endmodule

module ucr_uart import ucr_pkg::*; #(
    parameter int RX_DEPTH = 4
) (
    // Clock and resets
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       master_reset,
    // Register bus
    input  wire logic       chipSel,
    input  wire logic       rdStb,
    input  wire logic       wrStb,
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] wrData,
    output logic      [7:0] rdData,
    output logic            dataOe,
    // Serial link
    input  wire logic       serialIn,
    output logic            serialOut,
    // Modem pins, active low
    input  wire logic       ctsN,
    input  wire logic       dsrN,
    input  wire logic       riN,
    input  wire logic       dcdN,
    output logic            dtrN,
    output logic            rtsN,
    output logic            out1N,
    output logic            out2N,
    // Interrupt
    output logic            irqOut
);
    logic        clr;
    logic [7:0]  intEnable, lineControl, modemControl, scratchByte;
    logic [7:0]  txHolding, txShift;
    logic [15:0] divisor, baudCnt;
    logic [7:0]  divisorLow, divisorHigh;
    logic        tick, holdEmpty, threPend, txPar, txLine, txOut;
    logic        load, loop, rd, wr, dsel, divWr;
    ucr_tx_t     txState;
    ucr_rx_t     rxState;
    logic [5:0]  txCnt, rxCnt, stopTicks;
    logic [2:0]  txBit, rxBit, lastBit;
    logic [7:0]  rxShift, rxData, fifoHead, lsrVal, iirVal, regValue;
    logic        rxIn, rxParBit, rxPush, rxRead, inReady, outValid;
    logic [2:0]  rxErrSet;
    logic        overrun, parErr, frameErr, breakSeen;
    logic [3:0]  modemNow, modemPrev, modemDelta;
    logic        lsIrq, rxIrq, thIrq, msIrq, pend;
    logic [1:0]  iid;

    function automatic logic parityBit(input logic [7:0] d,
                                       input logic [7:0] line_control);
        logic x;
        x = ^(d & (8'hff >> (2'h3 - line_control[1:0])));
        if (line_control[LCR_STICK]) begin
            parityBit = ~line_control[LCR_EPS];
        end else begin
            parityBit = line_control[LCR_EPS] ? x : ~x;
        end
    endfunction

    assign clr     = !reset_n || master_reset;
    assign rd      = chipSel && rdStb;
    assign wr      = chipSel && wrStb;
    assign dsel    = lineControl[LCR_DSEL];
    assign loop    = modemControl[MCR_LOOP];
    assign divisor = {divisorHigh, divisorLow};
    assign lastBit = {1'b1, lineControl[1:0]};
    assign load    = tick && (txState == TX_IDLE) && !holdEmpty;
    assign rxRead  = rd && (regAddr == OFF_DATA) && !dsel;
    assign divWr   = wr && dsel
                     && (regAddr == OFF_DATA || regAddr == OFF_IER);

    // Divisor latches survive master reset
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            {divisorHigh, divisorLow} <= RST_DIV;
            txHolding   <= RST_BYTE;
            scratchByte <= RST_BYTE;
        end else if (wr) begin
            if (regAddr == OFF_DATA && dsel) divisorLow <= wrData;
            if (regAddr == OFF_IER && dsel) divisorHigh <= wrData;
            if (regAddr == OFF_DATA && !dsel) txHolding <= wrData;
            if (regAddr == OFF_SCR) scratchByte <= wrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clr) begin
            intEnable    <= RST_BYTE;
            lineControl  <= RST_BYTE;
            modemControl <= RST_BYTE;
        end else if (wr) begin
            if (regAddr == OFF_IER && !dsel) intEnable <= {4'h0, wrData[3:0]};
            if (regAddr == OFF_LCR) lineControl <= wrData;
            if (regAddr == OFF_MCR) modemControl <= {3'h0, wrData[4:0]};
        end
    end

    // 16x tick; divisor 0 behaves as 1; divisor write restarts count
    always_ff @(posedge core_clk) begin
        if (clr || (baudCnt <= 16'h0001 && !divWr)) begin
            baudCnt <= divisor;
            tick    <= !clr;
        end else if (divWr) begin
            baudCnt <= 16'h0001;
            tick    <= 1'b0;
        end else begin
            baudCnt <= baudCnt - 16'h0001;
            tick    <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clr) begin
            holdEmpty <= 1'b1;
        end else if (wr && regAddr == OFF_DATA && !dsel) begin
            holdEmpty <= 1'b0;
        end else if (load) begin
            holdEmpty <= 1'b1;
        end
    end

    always_comb begin
        if (!lineControl[LCR_STB]) begin
            stopTicks = STOP_ONE;
        end else if (lineControl[1:0] == 2'h0) begin
            stopTicks = STOP_HALF;
        end else begin
            stopTicks = STOP_TWO;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clr) begin
            txState <= TX_IDLE;
            txCnt   <= '0;
            txBit   <= '0;
            txShift <= RST_BYTE;
            txPar   <= 1'b1;
        end else if (tick) begin
            txCnt <= txCnt + 6'h01;
            case (txState)
                TX_IDLE: begin
                    txCnt <= '0;
                    if (!holdEmpty) begin
                        txShift <= txHolding;
                        txPar   <= parityBit(txHolding, lineControl);
                        txState <= TX_START;
                    end
                end
                TX_START: begin
                    if (txCnt == TICK_LAST) begin
                        txCnt   <= '0;
                        txBit   <= '0;
                        txState <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (txCnt == TICK_LAST) begin
                        txCnt   <= '0;
                        txShift <= txShift >> 1;
                        txBit   <= txBit + 3'h1;
                        if (txBit == lastBit) begin
                            txState <= lineControl[LCR_PEN] ? TX_PAR
                                                            : TX_STOP;
                        end
                    end
                end
                TX_PAR: begin
                    if (txCnt == TICK_LAST) begin
                        txCnt   <= '0;
                        txState <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (txCnt == stopTicks - 6'h01) begin
                        txCnt   <= '0;
                        txState <= TX_IDLE;
                    end
                end
                default: txState <= TX_IDLE;
            endcase
        end
    end

    always_comb begin
        case (txState)
            TX_START: txLine = 1'b0;
            TX_DATA:  txLine = txShift[0];
            TX_PAR:   txLine = txPar;
            default:  txLine = 1'b1;
        endcase
    end

    assign txOut = txLine && !lineControl[LCR_BRK];
    assign rxIn  = loop ? txOut : serialIn;

    always_ff @(posedge core_clk) begin
        if (clr) begin
            serialOut <= 1'b1;
        end else begin
            serialOut <= loop ? 1'b1 : txOut;
        end
    end

    always_ff @(posedge core_clk) begin
        rxPush   <= 1'b0;
        rxErrSet <= '0;
        if (clr) begin
            rxState  <= RX_IDLE;
            rxCnt    <= '0;
            rxBit    <= '0;
            rxShift  <= RST_BYTE;
            rxData   <= RST_BYTE;
            rxParBit <= 1'b0;
        end else if (tick) begin
            rxCnt <= rxCnt + 6'h01;
            case (rxState)
                RX_IDLE: begin
                    rxCnt <= '0;
                    if (!rxIn) begin
                        rxState <= RX_START;
                    end
                end
                RX_START: begin
                    if (rxCnt == TICK_MID) begin
                        rxCnt   <= '0;
                        rxBit   <= '0;
                        rxShift <= RST_BYTE;
                        rxState <= rxIn ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rxCnt == TICK_LAST) begin
                        rxCnt          <= '0;
                        rxShift[rxBit] <= rxIn;
                        rxBit          <= rxBit + 3'h1;
                        if (rxBit == lastBit) begin
                            rxParBit <= 1'b0;
                            rxState  <= lineControl[LCR_PEN] ? RX_PAR
                                                             : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rxCnt == TICK_LAST) begin
                        rxCnt    <= '0;
                        rxParBit <= rxIn;
                        rxState  <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    // Only the first stop bit is checked
                    if (rxCnt == TICK_LAST) begin
                        rxCnt       <= '0;
                        rxData      <= rxShift;
                        rxPush      <= 1'b1;
                        rxErrSet[0] <= lineControl[LCR_PEN] && (rxParBit
                                       != parityBit(rxShift, lineControl));
                        rxErrSet[1] <= !rxIn;
                        rxErrSet[2] <= !rxIn && rxShift == RST_BYTE
                                       && !rxParBit;
                        rxState     <= RX_IDLE;
                    end
                end
                default: rxState <= RX_IDLE;
            endcase
        end
    end

    ucr_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) rxFifo (
        .core_clk (core_clk),
        .clear    (clr),
        .inValid  (rxPush),
        .inReady  (inReady),
        .inData   (rxData),
        .outValid (outValid),
        .outReady (rxRead),
        .outData  (fifoHead)
    );

    // Error flags: a new event beats the clearing read
    always_ff @(posedge core_clk) begin
        if (clr) begin
            {breakSeen, frameErr, parErr, overrun} <= '0;
        end else begin
            overrun   <= (rxPush && !inReady)
                         || (overrun && !(rd && regAddr == OFF_LSR));
            parErr    <= rxErrSet[0] || (parErr && !(rd && regAddr == OFF_LSR));
            frameErr  <= rxErrSet[1]
                         || (frameErr && !(rd && regAddr == OFF_LSR));
            breakSeen <= rxErrSet[2]
                         || (breakSeen && !(rd && regAddr == OFF_LSR));
        end
    end

    assign lsrVal = {1'b0, holdEmpty && txState == TX_IDLE, holdEmpty,
                     breakSeen, frameErr, parErr, overrun, outValid};

    always_comb begin
        if (loop) begin
            modemNow = {modemControl[3], modemControl[2],
                        modemControl[0], modemControl[1]};
        end else begin
            modemNow = ~{dcdN, riN, dsrN, ctsN};
        end
    end

    always_ff @(posedge core_clk) begin
        modemPrev <= modemNow;
        if (clr) begin
            modemDelta <= '0;
        end else begin
            modemDelta[1:0] <= (modemNow[1:0] ^ modemPrev[1:0])
                | (modemDelta[1:0] & ~{2{rd && regAddr == OFF_MSR}});
            modemDelta[2] <= (modemPrev[2] && !modemNow[2])
                | (modemDelta[2] && !(rd && regAddr == OFF_MSR));
            modemDelta[3] <= (modemNow[3] ^ modemPrev[3])
                | (modemDelta[3] && !(rd && regAddr == OFF_MSR));
        end
    end

    assign lsIrq = intEnable[2] && (overrun | parErr | frameErr | breakSeen);
    assign rxIrq = intEnable[0] && outValid;
    assign thIrq = intEnable[1] && threPend;
    assign msIrq = intEnable[3] && (modemDelta != 4'h0);
    assign pend  = lsIrq | rxIrq | thIrq | msIrq;

    always_comb begin
        if (lsIrq) iid = IID_LINE;
        else if (rxIrq) iid = IID_RXD;
        else if (thIrq) iid = IID_HOLDING_EMPTY_FLAG;
        else iid = IID_MODEM;
    end

    assign iirVal = {5'h00, iid, ~pend};

    always_ff @(posedge core_clk) begin
        if (clr) begin
            threPend <= 1'b0;
        end else begin
            threPend <= (load && !(wr && regAddr == OFF_DATA && !dsel))
                || (threPend && !(wr && regAddr == OFF_DATA && !dsel)
                    && !(rd && regAddr == OFF_IIR && iid == IID_HOLDING_EMPTY_FLAG));
        end
    end

    always_comb begin
        case (regAddr)
            OFF_DATA: regValue = dsel ? divisorLow : fifoHead;
            OFF_IER:  regValue = dsel ? divisorHigh : intEnable;
            OFF_IIR:  regValue = iirVal;
            OFF_LCR:  regValue = lineControl;
            OFF_MCR:  regValue = modemControl;
            OFF_LSR:  regValue = lsrVal;
            OFF_MSR:  regValue = {modemPrev, modemDelta};
            default:  regValue = scratchByte;
        endcase
    end

    always_ff @(posedge core_clk) begin
        dataOe <= rd && reset_n;
        if (!reset_n) begin
            rdData <= RST_BYTE;
        end else if (rd) begin
            rdData <= regValue;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clr) begin
            {dtrN, rtsN, out1N, out2N, irqOut} <= 5'h1f;
            irqOut <= 1'b0;
        end else begin
            dtrN   <= !(modemControl[0] && !loop);
            rtsN   <= !(modemControl[1] && !loop);
            out1N  <= !(modemControl[2] && !loop);
            out2N  <= !(modemControl[3] && !loop);
            irqOut <= pend;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_mr_regs;
        master_reset |=> lineControl == RST_BYTE && intEnable == RST_BYTE
            && modemControl == RST_BYTE && iirVal == RST_IIR;
    endproperty
    a_mr_regs: assert property (p_mr_regs)
        else $error("control registers not cleared by master reset");
    property p_mr_pins;
        master_reset |=> serialOut && dtrN && rtsN && out1N && out2N
            && !irqOut;
    endproperty
    a_mr_pins: assert property (p_mr_pins)
        else $error("outputs not parked by master reset");
    property p_lsr_reset;
        master_reset |=> lsrVal == {1'b0, RST_LSR};
    endproperty
    a_lsr_reset: assert property (p_lsr_reset)
        else $error("line status wrong after master reset");
    property p_msr_reset;
        master_reset |=> modemDelta == 4'h0;
    endproperty
    a_msr_reset: assert property (p_msr_reset)
        else $error("modem change flags survive master reset");
    property p_thr_write;
        wr && regAddr == OFF_DATA && !dsel |=> !threPend && !holdEmpty;
    endproperty
    a_thr_write: assert property (p_thr_write)
        else $error("holding write did not drop its interrupt");
    property p_break;
        lineControl[LCR_BRK] && !loop && !master_reset |=> !serialOut;
    endproperty
    a_break: assert property (p_break)
        else $error("break did not force serial output low");
    property p_idle_ident;
        !pend |-> iirVal == RST_IIR;
    endproperty
    a_idle_ident: assert property (p_idle_ident)
        else $error("ident not 01 with nothing pending");
    property p_scratch;
        wr && regAddr == OFF_SCR ##1 !wr ##1 rd && !wr && regAddr == OFF_SCR
            |=> rdData == $past(wrData, 3) && dataOe;
    endproperty
    a_scratch: assert property (p_scratch)
        else $error("scratch byte did not read back");

    c_tx_start: cover property (txState == TX_START);
    c_rx_push: cover property (rxPush && inReady);
    c_overrun: cover property (rxPush && !inReady);
endmodule

`default_nettype wire

/* inc/ucr_pkg.sv */
// Purpose: Shared constants and state types of the serial transceiver
// Assumes: Byte-wide register bus, 16x baud tick from a divisor
// Notes:   Offsets are byte addresses on a 3-bit address bus
package ucr_pkg;
    localparam logic [2:0] OFF_DATA  = 3'h0;
    localparam logic [2:0] OFF_IER   = 3'h1;
    localparam logic [2:0] OFF_IIR   = 3'h2;
    localparam logic [2:0] OFF_LCR   = 3'h3;
    localparam logic [2:0] OFF_MCR   = 3'h4;
    localparam logic [2:0] OFF_LSR   = 3'h5;
    localparam logic [2:0] OFF_MSR   = 3'h6;
    localparam logic [2:0] OFF_SCR   = 3'h7;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] RST_IIR   = 8'h01;
    localparam logic [6:0] RST_LSR   = 7'h60;
    localparam logic [15:0] RST_DIV  = 16'h0001;
    localparam int LCR_STB   = 2;
    localparam int LCR_PEN   = 3;
    localparam int LCR_EPS   = 4;
    localparam int LCR_STICK = 5;
    localparam int LCR_BRK   = 6;
    localparam int LCR_DSEL  = 7;
    localparam int MCR_LOOP  = 4;
    localparam logic [1:0] IID_LINE  = 2'h3;
    localparam logic [1:0] IID_RXD   = 2'h2;
    localparam logic [1:0] IID_HOLDING_EMPTY_FLAG  = 2'h1;
    localparam logic [1:0] IID_MODEM = 2'h0;
    localparam logic [5:0] TICK_LAST = 6'h0f;
    localparam logic [5:0] TICK_MID  = 6'h07;
    localparam logic [5:0] STOP_ONE  = 6'h10;
    localparam logic [5:0] STOP_HALF = 6'h18;
    localparam logic [5:0] STOP_TWO  = 6'h20;
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
        TX_PAR  = 5'h08, TX_STOP  = 5'h10
    } ucr_tx_t;
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
        RX_PAR  = 5'h08, RX_STOP  = 5'h10
    } ucr_rx_t;
endpackage

/* bench/ucr_peer.sv */
// Purpose: Far-end serial peer for the transceiver bench
// Assumes: Divisor 1, so one bit lasts 16 clocks
// Notes:   Line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module ucr_peer (
    // Serial link
    input  wire logic core_clk,
    input  wire logic txLine,
    output logic      rxLine
);
    initial rxLine = 1'b1;
    task automatic bitTime(input logic b);
        rxLine = b;
        repeat (16) @(negedge core_clk);
    endtask
    // One 8N1 character
    task automatic send(input logic [7:0] b);
        bitTime(1'b0);
        for (int i = 0; i < 8; i++) bitTime(b[i]);
        bitTime(1'b1);
    endtask
    // n counts from mid last bit to next start edge
    task automatic recv(input logic [7:0] lc, output logic [7:0] d,
                        output logic p, output int n);
        n = 0;
        d = 8'h00;
        p = 1'b0;
        while (txLine !== 1'b0 && n < 999) begin
            @(negedge core_clk);
            n++;
        end
        repeat (8) @(negedge core_clk);
        for (int i = 0; i < 5 + lc[1:0] + lc[3]; i++) begin
            repeat (16) @(negedge core_clk);
            if (i < 5 + lc[1:0]) d[i] = txLine;
            else p = txLine;
        end
        n = 0;
        while (txLine !== 1'b1 && n < 99) begin
            @(negedge core_clk);
            n++;
        end
        while (txLine !== 1'b0 && n < 99) begin
            @(negedge core_clk);
            n++;
        end
    endtask
endmodule
`default_nettype wire

/* bench/ucr_uart_test.sv */
// Purpose: Self-checking bench for the serial transceiver
// Assumes: Inputs change on the falling clock edge
// Notes:   Divisor stays 1 while characters run
`timescale 1ns/1ps
`default_nettype none
module ucr_uart_test import ucr_pkg::*;;
    logic       core_clk = 1'b0, reset_n = 1'b0, master_reset = 1'b0;
    logic       chipSel = 1'b0, rdStb = 1'b0, wrStb = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] wrData = 8'h00, rdData, v, d, dm, lc;
    logic       ctsN = 1'b1, dsrN = 1'b1, riN = 1'b1, dcdN = 1'b1;
    logic       dataOe, serialIn, serialOut, irqOut, p, pe;
    logic       dtrN, rtsN, out1N, out2N;
    int         mismatches = 0, nTests = 0, cycles = 0, n, s;
    localparam logic [39:0] RSTV = 40'h60_00_00_01_00;
    localparam logic [18:0] REGROWS [6] = '{
        {OFF_LCR, 8'h1b, 8'h1b}, {OFF_IIR, 8'hff, 8'h01},
        {OFF_SCR, 8'ha5, 8'ha5}, {OFF_IER, 8'hff, 8'h0f},
        {OFF_MCR, 8'hef, 8'h0f}, {OFF_LSR, 8'h00, 8'h60}};
    localparam logic [11:0] MSROWS [4] = '{12'hf01, 12'hb40, 12'h4bf,
        12'hf0b};
    localparam logic [15:0] TXROWS [7] = '{16'h0015, 16'h052a, 16'h04ff,
        16'h1b5a, 16'h0a41, 16'h2b00, 16'h3b00};
    ucr_uart #(.RX_DEPTH(4)) u_ucr_uart (.core_clk, .reset_n,
        .master_reset, .chipSel, .rdStb, .wrStb, .regAddr, .wrData,
        .rdData, .dataOe, .serialIn, .serialOut, .ctsN, .dsrN, .riN,
        .dcdN, .dtrN, .rtsN, .out1N, .out2N, .irqOut);
    ucr_peer u_ucr_peer (.core_clk, .txLine(serialOut), .rxLine(serialIn));
    always #50 core_clk = ~core_clk;
    task automatic reportAndStop();
        if (mismatches == 0 && nTests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            reportAndStop();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] b);
        {chipSel, wrStb, regAddr, wrData} = {2'h3, a, b};
        @(negedge core_clk);
        {chipSel, wrStb} = 2'h0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] b);
        {chipSel, rdStb, regAddr} = {2'h3, a};
        @(negedge core_clk);
        {chipSel, rdStb} = 2'h0;
        b = rdData;
        chk({7'h00, dataOe}, 8'h01);
        @(negedge core_clk);
    endtask
    task automatic chkRst(input logic [7:0] modem_status);
        for (int a = 1; a < 6; a++) begin
            rd(3'(a), v);
            chk(v, RSTV[a*8-8 +: 8]);
        end
        rd(OFF_MSR, v);
        chk(v, modem_status);
        chk({2'h0, irqOut, serialOut, dtrN, rtsN, out1N, out2N}, 8'h1f);
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        chkRst(8'h00);
        foreach (REGROWS[i]) begin
            wr(REGROWS[i][18:16], REGROWS[i][15:8]);
            rd(REGROWS[i][18:16], v);
            chk(v, REGROWS[i][7:0]);
        end
        chk({4'h0, dtrN, rtsN, out1N, out2N}, 8'h00);
        wr(OFF_LCR, 8'h83);
        wr(OFF_IER, 8'h5a);
        rd(OFF_DATA, v);
        chk(v, 8'h01);
        rd(OFF_IER, v);
        chk(v, 8'h5a);
        ctsN = 1'b0;
        wr(OFF_LCR, 8'h43);
        rd(OFF_IER, v);
        chk(v, 8'h0f);
        chk({6'h00, irqOut, serialOut}, 8'h02);
        master_reset = 1'b1;
        @(negedge core_clk);
        master_reset = 1'b0;
        chkRst(8'h10);
        wr(OFF_LCR, 8'h80);
        rd(OFF_IER, v);
        chk(v, 8'h5a);
        wr(OFF_IER, 8'h00);
        wr(OFF_LCR, 8'h03);
        wr(OFF_IER, 8'h08);
        foreach (MSROWS[i]) begin
            {dcdN, riN, dsrN, ctsN} = MSROWS[i][11:8];
            repeat (4) @(negedge core_clk);
            chk({7'h00, irqOut}, {7'h00, |MSROWS[i][3:0]});
            rd(OFF_MSR, v);
            chk(v, MSROWS[i][7:0]);
            chk({7'h00, irqOut}, 8'h00);
        end
        wr(OFF_IER, 8'h01);
        u_ucr_peer.send(8'ha7);
        repeat (4) @(negedge core_clk);
        rd(OFF_IIR, v);
        chk(v, 8'h04);
        rd(OFF_DATA, v);
        chk(v, 8'ha7);
        chk({7'h00, irqOut}, 8'h00);
        for (int i = 0; i < 5; i++) u_ucr_peer.send(8'(i));
        rd(OFF_LSR, v);
        chk(v, 8'h63);
        for (int i = 0; i < 4; i++) begin
            rd(OFF_DATA, v);
            chk(v, 8'(i));
        end
        foreach (TXROWS[i]) begin
            lc = TXROWS[i][15:8];
            dm = TXROWS[i][7:0] & (8'hff >> (3 - lc[1:0]));
            pe = lc[3] & (lc[5] ? ~lc[4] : ^dm ^ ~lc[4]);
            s = lc[2] ? ((lc[1:0] == 2'h0) ? 24 : 32) : 16;
            wr(OFF_LCR, lc);
            fork
                begin
                    wr(OFF_DATA, TXROWS[i][7:0]);
                    repeat (3) @(negedge core_clk);
                    wr(OFF_DATA, TXROWS[i][7:0]);
                end
                begin
                    u_ucr_peer.recv(lc, d, p, n);
                    chk(d, dm);
                    chk({7'h00, p}, {7'h00, pe});
                    chk({7'h00, n >= s + 8 && n <= s + 10}, 8'h01);
                    u_ucr_peer.recv(lc, d, p, n);
                    chk(d, dm);
                end
            join
        end
        wr(OFF_LCR, 8'h43);
        chk({7'h00, serialOut}, 8'h00);
        wr(OFF_LCR, 8'h03);
        chk({7'h00, serialOut}, 8'h01);
        wr(OFF_MCR, 8'h1f);
        rd(OFF_MSR, v);
        chk(v, 8'hfb);
        chk({4'h0, dtrN, rtsN, out1N, out2N}, 8'h0f);
        wr(OFF_DATA, 8'h3c);
        chk({7'h00, serialOut}, 8'h01);
        repeat (200) @(negedge core_clk);
        rd(OFF_DATA, v);
        chk(v, 8'h3c);
        reportAndStop();
    end
endmodule
`default_nettype wire
